// [inc/srl_consts.vh]
// constants for the signal routing and latch matrix block
`ifndef SRL_CONSTS_VH
`define SRL_CONSTS_VH
`define SRL_CLK_MHZ        250
`define SRL_LED_DELAY_MS   10
`define SRL_LED_DELAY_CYC  (`SRL_LED_DELAY_MS * `SRL_CLK_MHZ * 1000)
`define SRL_BLINK_MS       250
`define SRL_BLINK_CYC      (`SRL_BLINK_MS * `SRL_CLK_MHZ * 1000)
`define SRL_TEST_MS        500
`define SRL_TEST_CYC       (`SRL_TEST_MS * `SRL_CLK_MHZ * 1000)
`define SRL_N_SRC          128
`define SRL_SEL_W          7
`define SRL_SRC_STAGE      0
`define SRL_SRC_PHYS       16
`define SRL_SRC_LOGIC      28
`define SRL_SRC_SOFT_IN    48
`define SRL_SRC_KEYS       52
`define SRL_SRC_LOCAL      54
`define SRL_SRC_PORTS      55
`define SRL_SRC_NET_ERR    60
`define SRL_SRC_NET_IN     64
`define SRL_MODE_NORMAL    2'h0
`define SRL_MODE_LATCHED   2'h1
`define SRL_MODE_FLASHING  2'h2
`endif

// [rtl/srl_led_cell.v]
// one indicator channel: settle delay, latch and blink for a single LED
`timescale 1ns/100ps
`include "srl_consts.vh"
module srl_led_cell #(
  parameter integer DELAY_CYC = `SRL_LED_DELAY_CYC
) (
  input  wire       clk_sys_i,
  input  wire       reset_i,
  input  wire       ctrl_i,
  input  wire [1:0] mode_i,
  input  wire       release_i,
  input  wire       blink_i,
  output wire       lit_o
);
  reg        settled_q;
  reg [31:0] cnt_q;
  reg        hold_q;

  // control must be stable for the delay before the LED state moves
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      settled_q <= 1'b0;
      cnt_q     <= 32'h0;
    end else if (ctrl_i == settled_q) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= DELAY_CYC - 1) begin
      settled_q <= ctrl_i;
      cnt_q     <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // hold flag: setting wins over release so an active control stays lit
  always @(posedge clk_sys_i) begin
    if (reset_i)
      hold_q <= 1'b0;
    else if (settled_q && mode_i != `SRL_MODE_NORMAL)
      hold_q <= 1'b1;
    else if (release_i)
      hold_q <= 1'b0;
  end

  assign lit_o = (mode_i == `SRL_MODE_FLASHING) ? ((settled_q | hold_q) & blink_i) :
                 (mode_i == `SRL_MODE_LATCHED)  ? (settled_q | hold_q) :
                 settled_q;
endmodule

// [rtl/srl_matrix.v]
// signal routing top: soft i/o, output and blocking crossbars, LED matrix
`timescale 1ns/100ps
`include "srl_consts.vh"
module srl_matrix #(
  parameter integer N_STAGE   = 16,
  parameter integer N_RELAY   = 8,
  parameter integer N_LED     = 14,
  parameter integer LED_DELAY = `SRL_LED_DELAY_CYC,
  parameter integer BLINK_CYC = `SRL_BLINK_CYC,
  parameter integer TEST_CYC  = `SRL_TEST_CYC
) (
  input  wire                       clk_sys_i,
  input  wire                       reset_i,
  // protection stage levels and the other crossbar sources
  input  wire [N_STAGE-1:0]         stage_start_i,
  input  wire [N_STAGE-1:0]         stage_trip_i,
  input  wire [N_STAGE-1:0]         stage_is_arc_i,
  input  wire [11:0]                phys_in_i,
  input  wire [19:0]                logic_out_i,
  input  wire                       function_key_one_i,
  input  wire                       function_key_two_i,
  input  wire                       local_sel_i,
  input  wire [4:0]                 port_active_i,
  input  wire [63:0]                network_in_i,
  input  wire [15:0]                network_error_flag_n_i,
  // soft input writes and their event enable
  input  wire [3:0]                 soft_input_wr_i,
  input  wire [3:0]                 soft_input_val_i,
  input  wire                       soft_in_event_en_i,
  // soft output direct writes, taken only while forced
  input  wire [5:0]                 soft_output_wr_i,
  input  wire [5:0]                 soft_output_val_i,
  input  wire                       soft_out_force_i,
  input  wire                       soft_out_event_en_i,
  // crossbar selections, one source index per sink
  input  wire [N_RELAY*`SRL_SEL_W-1:0] relay_sel_i,
  input  wire [N_RELAY-1:0]         relay_latch_i,
  input  wire [6*`SRL_SEL_W-1:0]    soft_out_sel_i,
  input  wire [`SRL_SEL_W-1:0]      capture_sel_i,
  input  wire [N_STAGE*`SRL_SEL_W-1:0] block_sel_i,
  input  wire [N_STAGE-1:0]         block_en_i,
  input  wire [N_LED*`SRL_SEL_W-1:0] led_sel_i,
  input  wire [N_LED*2-1:0]         led_mode_i,
  input  wire [N_LED-1:0]           led_red_i,
  // latch release origins; any one of them releases every latch
  input  wire                       release_phys_en_i,
  input  wire [3:0]                 release_phys_idx_i,
  input  wire                       release_panel_i,
  input  wire                       release_comm_i,
  input  wire                       enter_key_i,
  // panel state and keys for the lamp test
  input  wire                       password_open_i,
  input  wire                       info_key_i,
  input  wire                       s_key_i,
  input  wire                       first_window_i,
  // soft i/o state and change events
  output reg  [3:0]                 soft_input_n_o,
  output reg  [5:0]                 soft_output_n_o,
  output reg                        soft_in_event_o,
  output reg  [3:0]                 soft_in_event_bits_o,
  output reg                        soft_out_event_o,
  output reg  [5:0]                 soft_out_event_bits_o,
  // relays, capture trigger and stage blocks
  output reg  [N_RELAY-1:0]         relay_o,
  output reg                        disturbance_capture_trigger_o,
  output reg  [N_STAGE-1:0]         stage_block_o,
  // indicator drive
  output reg  [N_LED-1:0]           led_green_o,
  output reg  [N_LED-1:0]           led_red_o,
  output reg                        led_key_one_o,
  output reg                        led_key_two_o,
  output reg                        led_test_active_o
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_INFO = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  // soft i/o state, latch holds, blink phase and lamp test sequencer
  reg  [3:0]                 vin_q;
  reg  [5:0]                 vout_q;
  reg  [N_RELAY-1:0]         rly_hold_q;
  reg  [31:0]                blink_cnt_q;
  reg                        blink_q;
  reg  [1:0]                 tst_st_q;
  reg  [31:0]                tst_cnt_q;
  reg                        rel_q;
  // combinational crossbar results
  wire [`SRL_N_SRC-1:0]      src;
  wire                       rel_d;
  wire [N_LED-1:0]           led_lit;
  reg  [5:0]                 vout_d;
  reg  [N_RELAY-1:0]         rly_d;
  reg  [N_STAGE-1:0]         blk_d;
  // one loop index per process so that no variable has two drivers
  integer                    i;
  integer                    j;
  integer                    k;
  integer                    m;
  integer                    n;

  // select one bit out of the common source vector
  function pick;
    input [`SRL_N_SRC-1:0] s;
    input [`SRL_SEL_W-1:0] idx;
    begin
      pick = s[idx];
    end
  endfunction

  // shared source vector for every crossbar
  // limitation: only stage bits 7:0 and error flags 3:0 fit the 7-bit select
  assign src = {network_in_i,
                network_error_flag_n_i[3:0], port_active_i,
                local_sel_i,
                function_key_two_i, function_key_one_i,
                vin_q,
                logic_out_i,
                phys_in_i,
                stage_trip_i[7:0], stage_start_i[7:0]};

  // soft input state, latency one cycle which is far inside the 5 ms window
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      vin_q <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        if (soft_input_wr_i[i])
          vin_q[i] <= soft_input_val_i[i];
    end
  end

  // soft outputs: crossbar result unless forced, then the held value or the written one
  always @* begin
    for (j = 0; j < 6; j = j + 1)
      vout_d[j] = pick(src, soft_out_sel_i[j*`SRL_SEL_W +: `SRL_SEL_W]);
    // forced outputs keep their last value until written
    if (soft_out_force_i) begin
      vout_d = vout_q;
      for (j = 0; j < 6; j = j + 1)
        if (soft_output_wr_i[j])
          vout_d[j] = soft_output_val_i[j];
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      vout_q <= 6'h00;
    else
      vout_q <= vout_d;
  end

  // common release from any of its four origins
  // an index past the physical inputs selects nothing rather than an unknown bit
  assign rel_d = (release_phys_en_i & (release_phys_idx_i < 4'hC) & phys_in_i[release_phys_idx_i]) |
                 release_panel_i | release_comm_i | enter_key_i;

  always @(posedge clk_sys_i) begin
    if (reset_i)
      rel_q <= 1'b0;
    else
      rel_q <= rel_d;
  end

  // relay drive: follow or latch; set outweighs release
  always @* begin
    for (k = 0; k < N_RELAY; k = k + 1)
      rly_d[k] = pick(src, relay_sel_i[k*`SRL_SEL_W +: `SRL_SEL_W]);
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rly_hold_q <= {N_RELAY{1'b0}};
    end else begin
      for (m = 0; m < N_RELAY; m = m + 1)
        if (relay_latch_i[m] && rly_d[m])
          rly_hold_q[m] <= 1'b1;
        else if (rel_q || !relay_latch_i[m])
          rly_hold_q[m] <= 1'b0;
    end
  end

  // blocking crossbar; arc stages are masked regardless of settings
  always @* begin
    for (n = 0; n < N_STAGE; n = n + 1)
      blk_d[n] = block_en_i[n] & ~stage_is_arc_i[n] &
                 pick(src, block_sel_i[n*`SRL_SEL_W +: `SRL_SEL_W]);
  end

  // free-running blink phase shared by all flashing LEDs
  // limitation: flashing LEDs share one phase, so they always blink in step
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q >= BLINK_CYC - 1) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // LED channels, fed only from the crossbar
  genvar g;
  generate
    for (g = 0; g < N_LED; g = g + 1) begin : led_ch
      srl_led_cell #(
        .DELAY_CYC (LED_DELAY)
      ) u_cell (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ctrl_i    (pick(src, led_sel_i[g*`SRL_SEL_W +: `SRL_SEL_W])),
        .mode_i    (led_mode_i[g*2 +: 2]),
        .release_i (rel_q),
        .blink_i   (blink_q),
        .lit_o     (led_lit[g])
      );
    end
  endgenerate

  // LED test: info then S, password open, not on first window
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tst_st_q  <= ST_IDLE;
      tst_cnt_q <= 32'h0;
    end else begin
      case (tst_st_q)
        ST_IDLE: begin
          tst_cnt_q <= 32'h0;
          if (info_key_i && password_open_i && !first_window_i)
            tst_st_q <= ST_INFO;
        end
        // losing the password or reaching the first window drops a pending key pair
        ST_INFO: begin
          if (!password_open_i || first_window_i)
            tst_st_q <= ST_IDLE;
          else if (s_key_i)
            tst_st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (!password_open_i || tst_cnt_q >= TEST_CYC - 1)
            tst_st_q <= ST_IDLE;
          else
            tst_cnt_q <= tst_cnt_q + 32'h1;
        end
        default: tst_st_q <= ST_IDLE;
      endcase
    end
  end

  // registered outputs; events mark edges of group state when enabled
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      soft_input_n_o                <= 4'h0;
      soft_output_n_o               <= 6'h00;
      soft_in_event_o               <= 1'b0;
      soft_in_event_bits_o          <= 4'h0;
      soft_out_event_o              <= 1'b0;
      soft_out_event_bits_o         <= 6'h00;
      relay_o                       <= {N_RELAY{1'b0}};
      disturbance_capture_trigger_o <= 1'b0;
      stage_block_o                 <= {N_STAGE{1'b0}};
      led_green_o                   <= {N_LED{1'b0}};
      led_red_o                     <= {N_LED{1'b0}};
      led_key_one_o                 <= 1'b0;
      led_key_two_o                 <= 1'b0;
      led_test_active_o             <= 1'b0;
    end else begin
      // mirrors of soft i/o and their change masks
      soft_input_n_o        <= vin_q;
      soft_output_n_o       <= vout_q;
      soft_in_event_bits_o  <= soft_in_event_en_i ? (vin_q ^ soft_input_n_o) : 4'h0;
      soft_in_event_o       <= soft_in_event_en_i & (|(vin_q ^ soft_input_n_o));
      soft_out_event_bits_o <= soft_out_event_en_i ? (vout_q ^ soft_output_n_o) : 6'h00;
      soft_out_event_o      <= soft_out_event_en_i & (|(vout_q ^ soft_output_n_o));
      // latched relay shows live signal or hold, so a release while live leaves it on
      relay_o               <= rly_d | (rly_hold_q & relay_latch_i);
      disturbance_capture_trigger_o <= pick(src, capture_sel_i);
      stage_block_o         <= blk_d;
      // lamp test overrides every colour; bit 24 alternates slowly enough to see
      if (tst_st_q == ST_RUN) begin
        led_green_o <= {N_LED{~tst_cnt_q[24]}};
        led_red_o   <= {N_LED{tst_cnt_q[24]}};
      end else begin
        led_green_o <= led_lit & ~led_red_i;
        led_red_o   <= led_lit & led_red_i;
      end
      led_key_one_o         <= function_key_one_i | (tst_st_q == ST_RUN);
      led_key_two_o         <= function_key_two_i | (tst_st_q == ST_RUN);
      led_test_active_o     <= (tst_st_q == ST_RUN);
    end
  end
endmodule

// [test/srl_matrix_asserts.sv]
// checker for the routing matrix, bound to the top module's ports
`timescale 1ns/100ps
module srl_matrix_asserts #(
  parameter integer N_STAGE = 16,
  parameter integer N_RELAY = 8
) (
  input wire                 clk_sys_i,
  input wire                 reset_i,
  input wire [N_STAGE-1:0]   stage_is_arc_i,
  input wire [11:0]          phys_in_i,
  input wire                 function_key_one_i,
  input wire [3:0]           soft_input_wr_i,
  input wire [3:0]           soft_input_val_i,
  input wire                 soft_in_event_en_i,
  input wire [N_RELAY*7-1:0] relay_sel_i,
  input wire [N_RELAY-1:0]   relay_latch_i,
  input wire                 release_phys_en_i,
  input wire [3:0]           release_phys_idx_i,
  input wire                 release_panel_i,
  input wire                 release_comm_i,
  input wire                 enter_key_i,
  input wire                 password_open_i,
  input wire [3:0]           soft_input_n_o,
  input wire                 soft_in_event_o,
  input wire [3:0]           soft_in_event_bits_o,
  input wire [N_RELAY-1:0]   relay_o,
  input wire [N_STAGE-1:0]   stage_block_o,
  input wire                 led_key_one_o,
  input wire                 led_test_active_o
);
  // relay 0 follow and release checks apply only while it picks a physical input, the one range modelled here
  wire [6:0] sel0    = relay_sel_i[6:0];
  wire       phys0   = (sel0 >= 7'h10) && (sel0 < 7'h1C);
  wire [6:0] pidx    = sel0 - 7'h10;
  wire       live0   = phys_in_i[pidx[3:0]];
  wire       rel_any = release_panel_i | release_comm_i | enter_key_i | (release_phys_en_i & phys_in_i[release_phys_idx_i]);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_ARC_FREE: assert property (
    (stage_block_o & stage_is_arc_i & $past(stage_is_arc_i) & $past(stage_is_arc_i, 2)) == 0)
    else $error("arc stage shown as blocked");
  AST_SOFT_IN_LAT: assert property (
    soft_input_wr_i[0] |-> ##2 soft_input_n_o[0] == $past(soft_input_val_i[0], 2))
    else $error("soft input bit 0 did not take the written value");
  AST_IN_EVENT_OFF: assert property (
    (!soft_in_event_en_i)[*4] |=> !soft_in_event_o)
    else $error("soft input event while events are off");
  AST_IN_EVENT_BITS: assert property (
    soft_in_event_o |-> soft_in_event_bits_o == (soft_input_n_o ^ $past(soft_input_n_o)))
    else $error("event mask does not match the changed bits");
  AST_RELAY_FOLLOW: assert property (
    phys0 && $stable(sel0) && $past(sel0, 2) == sel0 && !relay_latch_i[0] && !$past(relay_latch_i[0])
    && !$past(relay_latch_i[0], 2) && !$past(reset_i) && !$past(reset_i, 2) |-> relay_o[0] == $past(live0))
    else $error("non-latched relay does not follow its source");
  AST_RELAY_HOLD: assert property (
    relay_latch_i[0] && $past(relay_latch_i[0]) && $past(relay_latch_i[0], 2) && relay_o[0] && $stable(sel0)
    && !rel_any && !$past(rel_any) && !$past(rel_any, 2) |=> relay_o[0])
    else $error("latched relay dropped without release");
  AST_RELEASE_CLEARS: assert property (
    phys0 && release_comm_i && !live0 && !$past(live0) && !$past(live0, 2) && $stable(sel0) && $past(sel0, 2) == sel0
    ##1 (!live0 && $stable(sel0))[*2] |=> !relay_o[0])
    else $error("release did not clear the relay");
  AST_TEST_PWD: assert property (
    $rose(led_test_active_o) |-> $past(password_open_i, 2))
    else $error("lamp test started without password");
  AST_KEY_LED: assert property (
    function_key_one_i == $past(function_key_one_i) && function_key_one_i == $past(function_key_one_i, 2)
    && !led_test_active_o && !$past(led_test_active_o) && !$past(reset_i) && !$past(reset_i, 2)
    |-> led_key_one_o == function_key_one_i)
    else $error("key lamp does not mirror its key");
endmodule

// [test/srl_relay_bank.sv]
// far-side relay bank: contacts pick up one cycle after their coils
`timescale 1ns/100ps
module srl_relay_bank #(
  parameter integer N = 8
) (
  input  wire         clk_sys_i,
  input  wire         reset_i,
  input  wire [N-1:0] coil_i,
  output reg  [N-1:0] contact_o
);
  // mechanical lag kept to one cycle so bench waits stay short
  always @(posedge clk_sys_i) begin
    if (reset_i)
      contact_o <= {N{1'b0}};
    else
      contact_o <= coil_i;
  end
endmodule

// [test/srl_matrix_bench.sv]
// self-checking bench for the routing and latch matrix
`timescale 1ns/100ps
module srl_matrix_bench;
  logic         clk_sys_i, reset_i, function_key_one_i, function_key_two_i, local_sel_i, soft_in_event_en_i;
  logic         soft_out_force_i, soft_out_event_en_i, release_phys_en_i, release_panel_i, release_comm_i;
  logic         enter_key_i, password_open_i, info_key_i, s_key_i, first_window_i, soft_in_event_o;
  logic         soft_out_event_o, disturbance_capture_trigger_o, led_key_one_o, led_key_two_o, led_test_active_o;
  logic [15:0]  stage_start_i, stage_trip_i, stage_is_arc_i, block_en_i, network_error_flag_n_i, stage_block_o;
  logic [11:0]  phys_in_i;
  logic [19:0]  logic_out_i;
  logic [4:0]   port_active_i;
  logic [63:0]  network_in_i;
  logic [3:0]   soft_input_wr_i, soft_input_val_i, release_phys_idx_i, soft_input_n_o, soft_in_event_bits_o;
  logic [5:0]   soft_output_wr_i, soft_output_val_i, soft_output_n_o, soft_out_event_bits_o;
  logic [55:0]  relay_sel_i;
  logic [7:0]   relay_latch_i, relay_o, contact_o;
  logic [41:0]  soft_out_sel_i;
  logic [6:0]   capture_sel_i;
  logic [111:0] block_sel_i;
  logic [97:0]  led_sel_i;
  logic [27:0]  led_mode_i;
  logic [13:0]  led_red_i, led_green_o, led_red_o;
  int           miscompares = 0;
  int           compares = 0;
  int           cycles = 0;

  srl_matrix #(.LED_DELAY(4), .BLINK_CYC(4), .TEST_CYC(64)) dut_u (.*);
  srl_relay_bank #(.N(8)) bank_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .coil_i(relay_o), .contact_o(contact_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard: the full sequence needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // look a nanosecond after the edge so the design's updates have landed
  task automatic look(input int n);
    tick(n);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // event pulses are collected over a window since their exact cycle is not the point here
  task automatic soft_in_write(input int k, input logic v, output logic [3:0] seen);
    tick(1);
    soft_input_wr_i <= 4'h1 << k;
    soft_input_val_i <= {4{v}};
    tick(1);
    soft_input_wr_i <= 4'h0;
    seen = 4'h0;
    repeat (5) begin
      look(1);
      if (soft_in_event_o === 1'b1)
        seen = seen | soft_in_event_bits_o;
    end
  endtask

  task automatic t_soft_in;
    logic [3:0] seen;
    soft_in_event_en_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      soft_in_write(k, 1'b1, seen);
      chk(soft_input_n_o, (16'h2 << k) - 16'h1);
      chk(seen, 16'h1 << k);
    end
    tick(1);
    soft_in_event_en_i <= 1'b0;
    soft_in_write(0, 1'b0, seen);
    chk(seen, 16'h0);
    chk(soft_input_n_o, 16'hE);
  endtask

  // direct writes count only while forced; crossbar source of every soft output is idle
  task automatic t_soft_out;
    logic [5:0] seen;
    tick(1);
    soft_out_event_en_i <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      tick(1);
      soft_out_force_i <= f[0];
      tick(1);
      soft_output_wr_i <= 6'h3F;
      soft_output_val_i <= 6'h2A;
      tick(1);
      soft_output_wr_i <= 6'h00;
      seen = 6'h00;
      repeat (4) begin
        look(1);
        if (soft_out_event_o === 1'b1)
          seen = seen | soft_out_event_bits_o;
      end
      chk(soft_output_n_o, f ? 16'h2A : 16'h0);
      chk(seen, f ? 16'h2A : 16'h0);
    end
    tick(1);
    soft_out_force_i <= 1'b0;
    soft_out_event_en_i <= 1'b0;
  endtask

  task automatic t_relay;
    tick(1);
    relay_sel_i[6:0] <= 7'h12;
    capture_sel_i <= 7'h45;
    tick(1);
    phys_in_i[2] <= 1'b1;
    network_in_i[5] <= 1'b1;
    look(5);
    chk({contact_o[0], disturbance_capture_trigger_o}, 16'h3);
    tick(1);
    phys_in_i[2] <= 1'b0;
    network_in_i[5] <= 1'b0;
    look(5);
    chk(contact_o[0], 16'h0);
    tick(1);
    relay_latch_i[0] <= 1'b1;
    release_phys_idx_i <= 4'h3;
    release_phys_en_i <= 1'b1;
    tick(1);
    phys_in_i[2] <= 1'b1;
    tick(1);
    release_comm_i <= 1'b1;
    tick(1);
    release_comm_i <= 1'b0;
    look(6);
    chk(contact_o[0], 16'h1);
    tick(1);
    phys_in_i[2] <= 1'b0;
    look(6);
    chk(contact_o[0], 16'h1);
    // three release sources in turn: panel, comms, then the chosen physical input
    for (int r = 0; r < 3; r++) begin
      tick(1);
      {release_panel_i, release_comm_i, phys_in_i[3]} <= 3'h4 >> r;
      tick(1);
      {release_panel_i, release_comm_i, phys_in_i[3]} <= 3'h0;
      look(6);
      chk(contact_o[0], 16'h0);
      tick(1);
      phys_in_i[2] <= 1'b1;
      tick(1);
      phys_in_i[2] <= 1'b0;
      look(6);
      chk(contact_o[0], 16'h1);
    end
    tick(1);
    release_panel_i <= 1'b1;
    release_phys_en_i <= 1'b0;
    tick(1);
    release_panel_i <= 1'b0;
    relay_latch_i[0] <= 1'b0;
  endtask

  // stages 0..3 blocked by physical input, physical input, stage trip, logic output; stage 1 is arc
  task automatic t_block;
    block_sel_i[27:0] <= {7'h1C, 7'h08, 7'h13, 7'h13};
    block_en_i[3:0] <= 4'hF;
    stage_is_arc_i[1] <= 1'b1;
    tick(1);
    phys_in_i[3] <= 1'b1;
    stage_trip_i[0] <= 1'b1;
    logic_out_i[0] <= 1'b1;
    look(5);
    chk(stage_block_o, 16'hD);
    tick(1);
    {phys_in_i[3], stage_trip_i[0], logic_out_i[0]} <= 3'h0;
    look(5);
    chk(stage_block_o, 16'h0);
  endtask

  // led 0 normal green, led 1 latched red, led 2 flashing green, led 3 normal green on local control
  task automatic t_led;
    logic on_seen;
    logic off_seen;
    tick(1);
    led_sel_i[20:0] <= {7'h16, 7'h15, 7'h14};
    led_sel_i[27:21] <= 7'h36;
    local_sel_i <= 1'b1;
    led_mode_i[5:0] <= {2'h2, 2'h1, 2'h0};
    led_red_i[2:0] <= 3'b010;
    tick(1);
    phys_in_i[6:4] <= 3'h7;
    look(2);
    chk(led_green_o[0], 16'h0);
    look(10);
    chk({led_red_o[1], led_green_o[0], led_red_o[0]}, 16'h6);
    chk(led_green_o[3], 16'h1);
    tick(1);
    phys_in_i[6:4] <= 3'h0;
    look(12);
    chk({led_red_o[1], led_green_o[0]}, 16'h2);
    on_seen = 1'b0;
    off_seen = 1'b0;
    repeat (12) begin
      look(1);
      on_seen = on_seen | (led_green_o[2] === 1'b1);
      off_seen = off_seen | (led_green_o[2] === 1'b0);
    end
    chk({on_seen, off_seen}, 16'h3);
    tick(1);
    enter_key_i <= 1'b1;
    tick(1);
    enter_key_i <= 1'b0;
    look(12);
    chk({led_green_o[2], led_red_o[1]}, 16'h0);
  endtask

  task automatic test_keys(input logic pwd, input logic first);
    tick(1);
    password_open_i <= pwd;
    first_window_i <= first;
    tick(1);
    info_key_i <= 1'b1;
    tick(1);
    info_key_i <= 1'b0;
    s_key_i <= 1'b1;
    tick(1);
    s_key_i <= 1'b0;
    look(3);
  endtask

  task automatic t_lamp_test;
    test_keys(1'b0, 1'b0);
    chk(led_test_active_o, 16'h0);
    test_keys(1'b1, 1'b1);
    chk(led_test_active_o, 16'h0);
    test_keys(1'b1, 1'b0);
    chk({led_test_active_o, led_key_one_o}, 16'h3);
    look(72);
    chk(led_test_active_o, 16'h0);
    tick(1);
    function_key_one_i <= 1'b1;
    look(4);
    chk({led_key_one_o, led_key_two_o}, 16'h2);
    tick(1);
    function_key_one_i <= 1'b0;
  endtask

  initial begin
    {stage_start_i, stage_trip_i, stage_is_arc_i, block_en_i, network_error_flag_n_i, phys_in_i, logic_out_i,
     port_active_i, network_in_i, soft_input_wr_i, soft_input_val_i, release_phys_idx_i, soft_output_wr_i,
     soft_output_val_i, relay_sel_i, relay_latch_i, soft_out_sel_i, capture_sel_i, block_sel_i, led_sel_i,
     led_mode_i, led_red_i, function_key_one_i, function_key_two_i, local_sel_i, soft_in_event_en_i,
     soft_out_force_i, soft_out_event_en_i, release_phys_en_i, release_panel_i, release_comm_i, enter_key_i,
     password_open_i, info_key_i, s_key_i, first_window_i} = '0;
    reset_i = 1'b1;
    tick(20);
    reset_i <= 1'b0;
    password_open_i <= 1'b1;
    t_soft_in();
    t_soft_out();
    t_relay();
    t_block();
    t_led();
    t_lamp_test();
    close_out();
  end
endmodule

bind srl_matrix srl_matrix_asserts #(.N_STAGE(N_STAGE), .N_RELAY(N_RELAY)) chk_u (.*);
